// ===== verilog/pae_top.sv
// Process alarm evaluator: Avalon-MM registers, banks and three alarms.
//
// How it works
// - Codes 1 to 7 select deviation kinds; code 0 is off.
// - Codes 8 to 15: absolute, loop, rate, remote.
// - Codes 1, 4, 5 use upper and lower limits.
// - Standby pair off when hysteresis bands overlap.
// - Standby pair off when limits cross and hysteresis is not negative.
// - Three selectors, each resets to upper deviation.
// - Output combines kind, value and hysteresis.
// - Values and limits stored per bank, active used.
// - Operation view writes go to active bank.
// - Each period compare value change with alarm value.
// - Period 1 to 999 sample cycles, default 17.
// - Value sign chooses rising or falling detection.
// - Remote kinds always compare the remote set point.
`timescale 1ns/1ps
`default_nettype none
module pae_top #(
   parameter int NUM_BANKS     = 8,
   parameter int SAMPLE_CYCLES = pae_pkg::SAMPLE_CYCLES
) (
   input  wire logic                          sys_clk,
   input  wire logic                          reset_n,
   input  wire logic                          clkEn,
   input  wire logic [pae_pkg::AW-1:0]        avsAddress,
   input  wire logic                          avsRead,
   input  wire logic                          avsWrite,
   input  wire logic [31:0]                   avsWriteData,
   output logic [31:0]                        avsReadData,
   output logic                               avsWaitRequest,
   input  wire logic signed [pae_pkg::DW-1:0] processValue,
   input  wire logic signed [pae_pkg::DW-1:0] setPoint,
   input  wire logic signed [pae_pkg::DW-1:0] remoteSetPoint,
   input  wire logic [$clog2(NUM_BANKS)-1:0]  activeBank,
   input  wire logic                          runStart,
   input  wire logic                          loopBreak,
   output logic [pae_pkg::NUM_ALM-1:0]        alarmOut,
   output logic                               irq
);
   import pae_pkg::*;
   localparam int BW = $clog2(NUM_BANKS);
   localparam int SW = $clog2(SAMPLE_CYCLES + 1);

   // Software-visible registers and internal state.
   logic [KW-1:0]        kind_q [NUM_ALM];
   logic [RATE_W-1:0]    ratePer_q;
   logic signed [DW-1:0] hys_q [NUM_ALM];
   logic [BW-1:0]        bankSel_q;
   logic signed [DW-1:0] val_q [NUM_BANKS][NUM_ALM];
   logic signed [DW-1:0] hi_q [NUM_BANKS][NUM_ALM];
   logic signed [DW-1:0] lo_q [NUM_BANKS][NUM_ALM];
   logic [NUM_ALM-1:0]   status_q;
   logic [NUM_ALM-1:0]   mask_q;
   logic [NUM_ALM-1:0]   alarmPrev_q;
   logic                 ack_q;
   logic [SW-1:0]        sampleCnt_q;

   // Bus and event terms.
   logic                 acc;
   logic                 wrAcc;
   logic                 rdAcc;
   logic                 isOp;
   logic [AW-1:0]        lowAddr;
   logic [BW-1:0]        bankIdx;
   logic [31:0]          rdNext;
   logic [RATE_W-1:0]    rateWr;
   logic                 sampleTick;
   logic                 rateTick;
   logic signed [DW:0]   delta;
   logic [NUM_ALM-1:0]   alarmNow;
   logic [NUM_ALM-1:0]   almRise;

   // Every access takes one wait cycle; the request is taken on the
   // edge where waitrequest is low, and read data are ready by then.
   assign avsWaitRequest = (avsRead || avsWrite) && !ack_q;
   assign acc     = (avsRead || avsWrite) && ack_q;
   assign wrAcc   = acc && avsWrite;
   assign rdAcc   = acc && avsRead;
   assign isOp    = avsAddress[OPVIEW_BIT];
   assign lowAddr = {1'b0, avsAddress[AW-2:0]};
   assign bankIdx = isOp ? activeBank : bankSel_q;

   // Wait-state toggle of the bus slave.
   always_ff @(posedge sys_clk)
      if (!reset_n)
         ack_q <= 1'b0;
      else if (clkEn)
         ack_q <= (avsRead || avsWrite) && !ack_q;

   // Rate period writes are clamped to the legal range.
   always_comb
   begin
      rateWr = avsWriteData[RATE_W-1:0];
      if (avsWriteData > 32'(RATE_MAX))
         rateWr = RATE_MAX;
      else if (rateWr < RATE_MIN)
         rateWr = RATE_MIN;
   end

   // Global configuration: kinds, rate period, hysteresis, bank view.
   always_ff @(posedge sys_clk)
      if (!reset_n)
      begin
         for (int i = 0; i < NUM_ALM; i++)
         begin
            kind_q[i] <= KIND_RESET;
            hys_q[i]  <= '0;
         end
         ratePer_q <= RATE_RESET;
         bankSel_q <= '0;
      end
      else if (clkEn && wrAcc)
      begin
         if (avsAddress == REG_KIND)
            for (int i = 0; i < NUM_ALM; i++)
               kind_q[i] <= avsWriteData[i*KIND_FW +: KW];
         if (avsAddress == REG_RATE)
            ratePer_q <= rateWr;
         for (int i = 0; i < NUM_ALM; i++)
            if (hit(avsAddress, REG_HYS, i))
               hys_q[i] <= avsWriteData[DW-1:0];
         if (avsAddress == REG_BANKSEL)
            bankSel_q <= avsWriteData[BW-1:0];
      end

   // Banked alarm values; the operation view lands in the active bank.
   always_ff @(posedge sys_clk)
      if (!reset_n)
      begin
         for (int b = 0; b < NUM_BANKS; b++)
            for (int i = 0; i < NUM_ALM; i++)
            begin
               val_q[b][i] <= '0;
               hi_q[b][i]  <= '0;
               lo_q[b][i]  <= '0;
            end
      end
      else if (clkEn && wrAcc)
      begin
         for (int i = 0; i < NUM_ALM; i++)
         begin
            if (hit(lowAddr, REG_VAL, i))
               val_q[bankIdx][i] <= avsWriteData[DW-1:0];
            if (hit(lowAddr, REG_HI, i))
               hi_q[bankIdx][i] <= avsWriteData[DW-1:0];
            if (hit(lowAddr, REG_LO, i))
               lo_q[bankIdx][i] <= avsWriteData[DW-1:0];
         end
      end

   // Interrupt mask register.
   always_ff @(posedge sys_clk)
      if (!reset_n)
         mask_q <= '0;
      else if (clkEn && wrAcc && avsAddress == REG_MASK)
         mask_q <= avsWriteData[NUM_ALM-1:0];

   // Sticky alarm onsets; a new onset in the clearing read survives.
   assign almRise = alarmNow & ~alarmPrev_q;
   always_ff @(posedge sys_clk)
      if (!reset_n)
      begin
         status_q    <= '0;
         alarmPrev_q <= '0;
      end
      else if (clkEn)
      begin
         alarmPrev_q <= alarmNow;
         status_q    <= almRise |
            ((rdAcc && avsAddress == REG_STATUS) ? '0 : status_q);
      end

   assign irq = |(status_q & mask_q);

   // Read mux; unmapped addresses read as zero.
   always_comb
   begin
      rdNext = '0;
      if (avsAddress == REG_KIND)
         rdNext = 32'({kind_q[2], kind_q[1], kind_q[0]});
      if (avsAddress == REG_RATE)
         rdNext = 32'(ratePer_q);
      if (avsAddress == REG_BANKSEL)
         rdNext = 32'(bankSel_q);
      if (avsAddress == REG_STATUS)
         rdNext = 32'(status_q);
      if (avsAddress == REG_MASK)
         rdNext = 32'(mask_q);
      if (avsAddress == REG_LIVE)
         rdNext = 32'(alarmNow);
      for (int i = 0; i < NUM_ALM; i++)
      begin
         if (hit(avsAddress, REG_HYS, i))
            rdNext = zx(hys_q[i]);
         if (hit(lowAddr, REG_VAL, i))
            rdNext = zx(val_q[bankIdx][i]);
         if (hit(lowAddr, REG_HI, i))
            rdNext = zx(hi_q[bankIdx][i]);
         if (hit(lowAddr, REG_LO, i))
            rdNext = zx(lo_q[bankIdx][i]);
      end
   end

   // Read data is captured in the wait cycle so it stands at the
   // accepting edge and holds until the next read.
   always_ff @(posedge sys_clk)
      if (!reset_n)
         avsReadData <= '0;
      else if (clkEn && avsRead && !ack_q)
         avsReadData <= rdNext;

   // Sampling cycle strobe; long count, so shorten it in simulation.
   assign sampleTick = sampleCnt_q == SW'(SAMPLE_CYCLES - 1);
   always_ff @(posedge sys_clk)
      if (!reset_n)
         sampleCnt_q <= '0;
      else if (clkEn)
         sampleCnt_q <= sampleTick ? '0 : sampleCnt_q + SW'(1);

   // Shared rate-of-change calculator.
   pae_rate_calc #(
      .PER_W      (RATE_W)
   ) u_rate (
      .sys_clk    (sys_clk),
      .reset_n    (reset_n),
      .clkEn      (clkEn),
      .sampleTick (sampleTick),
      .period     (ratePer_q),
      .pv         (processValue),
      .delta      (delta),
      .tick       (rateTick)
   );

   // One evaluator per alarm, fed the active bank's settings.
   pae_eval_if evIf [NUM_ALM] ();
   for (genvar g = 0; g < NUM_ALM; g++)
   begin : g_alm
      assign evIf[g].kind      = kind_q[g];
      assign evIf[g].pv        = processValue;
      assign evIf[g].sp        = setPoint;
      assign evIf[g].rsp       = remoteSetPoint;
      assign evIf[g].val       = val_q[activeBank][g];
      assign evIf[g].hi        = hi_q[activeBank][g];
      assign evIf[g].lo        = lo_q[activeBank][g];
      assign evIf[g].hys       = hys_q[g];
      assign evIf[g].delta     = delta;
      assign evIf[g].rateTick  = rateTick;
      assign evIf[g].loopBreak = loopBreak;
      assign evIf[g].allowLoop = g == 0;
      assign evIf[g].runStart  = runStart;
      assign alarmNow[g]       = evIf[g].alarm;
      pae_alarm_eval u_eval (
         .sys_clk (sys_clk),
         .reset_n (reset_n),
         .clkEn   (clkEn),
         .e       (evIf[g])
      );
   end

   // Live alarm levels leave straight from the evaluator flip-flops.
   assign alarmOut = alarmNow;

   a_kind_reset: assert property (@(posedge sys_clk)
      !reset_n |=> kind_q[0] == KIND_RESET && kind_q[1] == KIND_RESET &&
                   kind_q[2] == KIND_RESET)
      else $error("Alarm kind did not reset to upper deviation.");
   a_opview_bank: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      (clkEn && wrAcc && isOp && hit(lowAddr, REG_VAL, 0)) |=>
      val_q[$past(activeBank)][0] == $past(avsWriteData[DW-1:0]))
      else $error("Operation view write missed the active bank.");
   a_wait_single: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      (clkEn && avsRead && avsWaitRequest) |=> !avsWaitRequest)
      else $error("Bus slave held waitrequest beyond one cycle.");
   a_status_clear: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      (clkEn && rdAcc && avsAddress == REG_STATUS) |=>
      status_q == $past(almRise))
      else $error("Status read did not clear the sticky bits.");
   c_irq_rise: cover property (@(posedge sys_clk) $rose(irq));
   c_opview_write: cover property (@(posedge sys_clk)
      wrAcc && isOp && activeBank != bankSel_q);
endmodule
`default_nettype wire

// ===== verilog/pae_pkg.sv
// Shared constants, types and helpers of the process alarm evaluator.
package pae_pkg;
   // Data and field widths.
   localparam int DW      = 16;
   localparam int KW      = 4;
   localparam int AW      = 8;
   localparam int RATE_W  = 10;
   localparam int NUM_ALM = 3;
   localparam int KIND_FW = 4;

   typedef logic signed [DW+1:0] pae_wide_t;

   // Alarm kind selector codes.
   localparam logic [KW-1:0] K_OFF       = 4'h0;
   localparam logic [KW-1:0] K_BAND      = 4'h1;
   localparam logic [KW-1:0] K_DEV_HI    = 4'h2;
   localparam logic [KW-1:0] K_DEV_LO    = 4'h3;
   localparam logic [KW-1:0] K_RANGE     = 4'h4;
   localparam logic [KW-1:0] K_BAND_SB   = 4'h5;
   localparam logic [KW-1:0] K_DEV_HI_SB = 4'h6;
   localparam logic [KW-1:0] K_DEV_LO_SB = 4'h7;
   localparam logic [KW-1:0] K_ABS_HI    = 4'h8;
   localparam logic [KW-1:0] K_ABS_LO    = 4'h9;
   localparam logic [KW-1:0] K_ABS_HI_SB = 4'ha;
   localparam logic [KW-1:0] K_ABS_LO_SB = 4'hb;
   localparam logic [KW-1:0] K_LOOP      = 4'hc;
   localparam logic [KW-1:0] K_RATE      = 4'hd;
   localparam logic [KW-1:0] K_RSP_HI    = 4'he;
   localparam logic [KW-1:0] K_RSP_LO    = 4'hf;

   // Reset values and limits.
   localparam logic [KW-1:0]     KIND_RESET = K_DEV_HI;
   localparam logic [RATE_W-1:0] RATE_RESET = 10'h011;
   localparam logic [RATE_W-1:0] RATE_MIN   = 10'h001;
   localparam logic [RATE_W-1:0] RATE_MAX   = 10'h3e7;

   // Sampling cycle timing.
   localparam int CLK_PERIOD_NS    = 25;
   localparam int SAMPLE_PERIOD_MS = 60;
   localparam int SAMPLE_CYCLES    =
      SAMPLE_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

   // Register byte offsets; bit OPVIEW_BIT maps banked words to the
   // active bank.
   localparam logic [AW-1:0] REG_KIND    = 8'h00;
   localparam logic [AW-1:0] REG_RATE    = 8'h04;
   localparam logic [AW-1:0] REG_HYS     = 8'h08;
   localparam logic [AW-1:0] REG_BANKSEL = 8'h14;
   localparam logic [AW-1:0] REG_VAL     = 8'h18;
   localparam logic [AW-1:0] REG_HI      = 8'h24;
   localparam logic [AW-1:0] REG_LO      = 8'h30;
   localparam logic [AW-1:0] REG_STATUS  = 8'h50;
   localparam logic [AW-1:0] REG_MASK    = 8'h54;
   localparam logic [AW-1:0] REG_LIVE    = 8'h58;
   localparam int            OPVIEW_BIT  = 7;

   // True when the address names word i of a three-word group.
   function automatic logic hit(input logic [AW-1:0] a,
                                input logic [AW-1:0] base,
                                input int            i);
      return a == base + AW'(4 * i);
   endfunction

   // Zero-extends a data value onto the bus.
   function automatic logic [31:0] zx(input logic [DW-1:0] v);
      return {{(32-DW){1'b0}}, v};
   endfunction

   // Standby kinds hold the output off until a first quiet sample.
   function automatic logic isStandby(input logic [KW-1:0] k);
      return k == K_BAND_SB || k == K_DEV_HI_SB || k == K_DEV_LO_SB ||
             k == K_ABS_HI_SB || k == K_ABS_LO_SB;
   endfunction
endpackage

// ===== verilog/pae_eval_if.sv
// Bundle between the register block and one alarm evaluator.
`timescale 1ns/1ps
`default_nettype none
interface pae_eval_if;
   import pae_pkg::*;
   logic [KW-1:0]        kind;
   logic signed [DW-1:0] pv;
   logic signed [DW-1:0] sp;
   logic signed [DW-1:0] rsp;
   logic signed [DW-1:0] val;
   logic signed [DW-1:0] hi;
   logic signed [DW-1:0] lo;
   logic signed [DW-1:0] hys;
   logic signed [DW:0]   delta;
   logic                 rateTick;
   logic                 loopBreak;
   logic                 allowLoop;
   logic                 runStart;
   logic                 alarm;
   modport ctrl (output kind, pv, sp, rsp, val, hi, lo, hys, delta,
                 rateTick, loopBreak, allowLoop, runStart, input alarm);
   modport eval (input kind, pv, sp, rsp, val, hi, lo, hys, delta,
                 rateTick, loopBreak, allowLoop, runStart, output alarm);
endinterface
`default_nettype wire

// ===== verilog/pae_rate_calc.sv
// Process value change over a programmable number of sampling cycles.
`timescale 1ns/1ps
`default_nettype none
module pae_rate_calc #(
   parameter int PER_W = 10
) (
   input  wire logic                           sys_clk,
   input  wire logic                           reset_n,
   input  wire logic                           clkEn,
   input  wire logic                           sampleTick,
   input  wire logic [PER_W-1:0]               period,
   input  wire logic signed [pae_pkg::DW-1:0]  pv,
   output logic signed [pae_pkg::DW:0]         delta,
   output logic                                tick
);
   import pae_pkg::*;
   logic [PER_W-1:0]     cnt_q;
   logic signed [DW-1:0] prev_q;
   logic                 primed_q;
   logic                 fire;

   // The >= guards against a period lowered below the running count.
   assign fire = sampleTick && (cnt_q >= period - PER_W'(1));

   // Sampling cycles counted inside one calculation period.
   always_ff @(posedge sys_clk)
      if (!reset_n)
         cnt_q <= '0;
      else if (clkEn && sampleTick)
         cnt_q <= fire ? '0 : cnt_q + PER_W'(1);

   // The first period has no predecessor, so its difference is hidden.
   always_ff @(posedge sys_clk)
      if (!reset_n)
      begin
         prev_q   <= '0;
         delta    <= '0;
         tick     <= 1'b0;
         primed_q <= 1'b0;
      end
      else if (clkEn)
      begin
         tick <= fire && primed_q;
         if (fire)
         begin
            delta    <= (DW+1)'(pv) - (DW+1)'(prev_q);
            prev_q   <= pv;
            primed_q <= 1'b1;
         end
      end

   a_rate_delta: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (clkEn && fire) |=> delta == (DW+1)'($past(pv)) - $past(prev_q))
      else $error("Rate difference does not match the sampled values.");
   a_rate_period: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (clkEn && sampleTick && !fire) |=> !tick)
      else $error("Rate period ended before its count of samples.");
   c_rate_tick: cover property (@(posedge sys_clk) disable iff (!reset_n)
      tick);
endmodule
`default_nettype wire

// ===== verilog/pae_alarm_eval.sv
// One alarm channel: kind decode, thresholds, hysteresis and standby.
`timescale 1ns/1ps
`default_nettype none
module pae_alarm_eval (
   input  wire logic  sys_clk,
   input  wire logic  reset_n,
   input  wire logic  clkEn,
   pae_eval_if.eval   e
);
   import pae_pkg::*;
   pae_wide_t subj, hiThr, loThr, hysW;
   logic devKind, pairKind, hiOn, loOn, raw, outNow;
   logic hiState_q, loState_q, sbArmed_q, rateOn_q, alarm_q;

   // Deviation kinds offset from the set point, absolute kinds do not.
   always_comb
   begin
      devKind  = e.kind >= K_BAND && e.kind <= K_DEV_LO_SB;
      pairKind = e.kind == K_BAND || e.kind == K_RANGE ||
                 e.kind == K_BAND_SB;
      subj     = (e.kind == K_RSP_HI || e.kind == K_RSP_LO) ?
                 pae_wide_t'(e.rsp) : pae_wide_t'(e.pv);
      hysW     = pae_wide_t'(e.hys);
      hiThr    = (devKind ? pae_wide_t'(e.sp) : '0) +
                 pae_wide_t'(pairKind ? e.hi : e.val);
      loThr    = devKind ? pae_wide_t'(e.sp) -
                 pae_wide_t'(pairKind ? e.lo : e.val) : pae_wide_t'(e.val);
      hiOn     = hiState_q ? subj > hiThr - hysW : subj > hiThr;
      loOn     = loState_q ? subj < loThr + hysW : subj < loThr;
   end

   // Raw condition per kind; the paired standby kind stays off when
   // its two release bands meet, which covers crossed limits when the hysteresis is not negative.
   always_comb
   begin
      case (e.kind)
         K_OFF: raw = 1'b0;
         K_BAND: raw = hiOn || loOn || hiThr <= loThr;
         K_BAND_SB: raw = (hiOn || loOn) &&
                          hiThr - hysW > loThr + hysW;
         K_DEV_HI, K_DEV_HI_SB, K_ABS_HI, K_ABS_HI_SB, K_RSP_HI:
            raw = hiOn;
         K_DEV_LO, K_DEV_LO_SB, K_ABS_LO, K_ABS_LO_SB, K_RSP_LO:
            raw = loOn;
         K_RANGE: raw = subj >= loThr && subj <= hiThr;
         K_LOOP: raw = e.allowLoop && e.loopBreak;
         K_RATE: raw = rateOn_q;
         default: raw = 1'b0;
      endcase
      outNow = raw && (!isStandby(e.kind) ||
               (sbArmed_q && !e.runStart));
   end

   // Hysteresis memory, standby arming and the registered output.
   always_ff @(posedge sys_clk)
      if (!reset_n)
      begin
         hiState_q <= 1'b0;
         loState_q <= 1'b0;
         sbArmed_q <= 1'b0;
         alarm_q   <= 1'b0;
      end
      else if (clkEn)
      begin
         hiState_q <= hiOn;
         loState_q <= loOn;
         sbArmed_q <= !e.runStart && (sbArmed_q || !raw);
         alarm_q   <= outNow;
      end

   // Rate verdict refreshed once per calculation period.
   always_ff @(posedge sys_clk)
      if (!reset_n)
         rateOn_q <= 1'b0;
      else if (clkEn && e.rateTick)
         rateOn_q <= e.val >= 0 ? e.delta > (DW+1)'(e.val) :
                                  e.delta < (DW+1)'(e.val);

   assign e.alarm = alarm_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_off_kind_quiet: assert property (
      (clkEn && e.kind == K_OFF) |=> !e.alarm)
      else $error("Disabled alarm drove its output.");
   a_loop_first_only: assert property (
      (clkEn && e.kind == K_LOOP && !e.allowLoop) |=> !e.alarm)
      else $error("Loop break alarm fired on a later channel.");
   a_band_overlap_off: assert property (
      (clkEn && e.kind == K_BAND_SB && hiThr - hysW <= loThr + hysW)
      |=> !e.alarm)
      else $error("Standby band alarm fired with overlapping bands.");
   a_crossed_limits_off: assert property (
      (clkEn && e.kind == K_BAND_SB && hiThr <= loThr) |=> !e.alarm)
      else $error("Standby band alarm fired with crossed limits.");
   a_standby_hold: assert property (
      (clkEn && e.runStart && isStandby(e.kind)) |=> !e.alarm)
      else $error("Standby alarm fired at operation start.");
   a_absolute_upper: assert property (
      (clkEn && e.kind == K_ABS_HI && e.hys >= 0 && subj > pae_wide_t'(e.val))
      |=> e.alarm)
      else $error("Absolute upper alarm missed its threshold.");
   c_standby_release: cover property (
      isStandby(e.kind) && !raw ##1 raw [*2] ##1 e.alarm);
endmodule
`default_nettype wire

// ===== testbench/test_process_alarm_evaluator.sv
// Self-checking bench for the process alarm evaluator.
`timescale 1ns/1ps
`default_nettype none
module test_process_alarm_evaluator;
   import pae_pkg::*;
   typedef struct {logic [3:0] k; logic [15:0] v, h, l, p; logic e;} pae_row_s;
   logic               sys_clk, reset_n, avsRead, avsWrite, runStart;
   logic               loopBreak, avsWaitRequest, irq;
   logic [7:0]         avsAddress;
   logic [31:0]        avsWriteData, avsReadData, rd;
   logic [2:0]         alarmOut, activeBank;
   logic signed [15:0] processValue, setPoint, remoteSetPoint;
   int                 errCount, testsRun;
   // Ordinary cases with set point 0x64 and remote set point 0xa0.
   pae_row_s rows [15] = '{
      '{K_OFF, 16'h0a, 0, 0, 16'hc8, 0}, '{K_DEV_HI, 16'h0a, 0, 0, 16'h6f, 1},
      '{K_DEV_HI, 16'h0a, 0, 0, 16'h6e, 0}, '{K_DEV_LO, 16'h0a, 0, 0, 16'h59, 1},
      '{K_DEV_LO, 16'h0a, 0, 0, 16'h5a, 0}, '{K_BAND, 0, 16'ha, 16'ha, 16'h55, 1},
      '{K_BAND, 0, 16'ha, 16'ha, 16'h64, 0},
      '{K_BAND, 0, 16'hfff6, 16'ha, 16'h64, 1},
      '{K_RANGE, 0, 16'ha, 16'ha, 16'h64, 1},
      '{K_RANGE, 0, 16'ha, 16'ha, 16'h6f, 0},
      '{K_ABS_HI, 16'h96, 0, 0, 16'h97, 1}, '{K_ABS_LO, 16'h96, 0, 0, 16'h97, 0},
      '{K_RSP_HI, 16'h96, 0, 0, 0, 1}, '{K_RSP_LO, 16'h96, 0, 0, 0, 0},
      '{K_BAND_SB, 0, 16'hfff6, 16'ha, 16'h64, 0}};

   pae_top #(.SAMPLE_CYCLES(4)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
      .clkEn(1'b1), .avsAddress(avsAddress), .avsRead(avsRead),
      .avsWrite(avsWrite), .avsWriteData(avsWriteData),
      .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
      .processValue(processValue), .setPoint(setPoint),
      .remoteSetPoint(remoteSetPoint), .activeBank(activeBank),
      .runStart(runStart), .loopBreak(loopBreak), .alarmOut(alarmOut),
      .irq(irq));

   // Free-running 40 MHz clock.
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Prints the counts and the verdict, then stops.
   task automatic end_of_test;
      $display("Counts: %0d errors in %0d checks", errCount, testsRun);
      if (errCount == 0 && testsRun > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp)
      begin
         errCount++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One Avalon access, raised just after a rising edge. Waitrequest and
   // read data are read at each rising edge before the design updates, so
   // the edge that sees waitrequest low is the accepting edge.
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      avsAddress <= a;
      avsWriteData <= d;
      avsWrite <= w;
      avsRead <= ~w;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (avsWaitRequest !== 1'b0 && n < 20);
      if (avsWaitRequest !== 1'b0)
      begin
         errCount++;
         $display("BAD %0t bus hang", $time);
         end_of_test;
      end
      rd = avsReadData;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask

   // Writes value, upper and lower limit of alarm 1 in the active bank.
   task automatic vals(input logic [15:0] v, h, l);
      bus(1'b1, 8'h98, {16'h0, v});
      bus(1'b1, 8'ha4, {16'h0, h});
      bus(1'b1, 8'hb0, {16'h0, l});
   endtask

   // A ramp in the direction of the value's sign must raise the alarm.
   // The bench reads the live level; a latch in software is advised.
   task automatic ramp(input logic [15:0] s);
      repeat (40) @(posedge sys_clk) processValue <= processValue + s;
      chk({31'h0, alarmOut[0]}, 32'h1);
   endtask

   // Main sequence: reset, table rows, then the awkward cases.
   initial
   begin
      {reset_n, avsRead, avsWrite, runStart, loopBreak} = 5'h0;
      {avsAddress, avsWriteData, activeBank} = 43'h0;
      {processValue, setPoint, remoteSetPoint} = {16'h0, 16'h64, 16'ha0};
      errCount = 0;
      testsRun = 0;
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      rdc(REG_KIND, 32'h222);
      rdc(REG_RATE, 32'h11);
      bus(1'b1, REG_RATE, 32'h3e8);
      rdc(REG_RATE, 32'h3e7);
      bus(1'b1, REG_RATE, 32'h0);
      rdc(REG_RATE, 32'h1);
      rdc(8'h40, 32'h0);
      foreach (rows[i])
      begin
         bus(1'b1, REG_KIND, {28'h0, rows[i].k});
         vals(rows[i].v, rows[i].h, rows[i].l);
         processValue <= rows[i].p;
         repeat (3) @(posedge sys_clk);
         chk({31'h0, alarmOut[0]}, {31'h0, rows[i].e});
      end
      // Masked event, then unmasked, then cleared by the status read.
      bus(1'b0, REG_STATUS, 32'h0);
      bus(1'b1, REG_KIND, 32'h2);
      vals(16'ha, 0, 0);
      processValue <= 16'h6f;
      repeat (3) @(posedge sys_clk);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, REG_MASK, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rdc(REG_STATUS, 32'h1);
      chk({31'h0, irq}, 32'h0);
      rdc(REG_LIVE, 32'h1);
      // Bank 3 holds a zero value while the active bank 0 holds 0x0a.
      bus(1'b1, REG_BANKSEL, 32'h3);
      bus(1'b1, REG_VAL, 32'h0);
      processValue <= 16'h69;
      repeat (3) @(posedge sys_clk);
      chk({31'h0, alarmOut[0]}, 32'h0);
      activeBank <= 3'h3;
      repeat (3) @(posedge sys_clk);
      chk({31'h0, alarmOut[0]}, 32'h1);
      rdc(8'h98, 32'h0);
      activeBank <= 3'h0;
      rdc(8'h98, 32'ha);
      // Standby holds off until the value has been quiet once.
      bus(1'b1, REG_KIND, 32'h6);
      processValue <= 16'h6f;
      runStart <= 1'b1;
      @(posedge sys_clk) runStart <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk({31'h0, alarmOut[0]}, 32'h0);
      processValue <= 16'h64;
      repeat (3) @(posedge sys_clk) processValue <= 16'h6f;
      repeat (3) @(posedge sys_clk);
      chk({31'h0, alarmOut[0]}, 32'h1);
      // Loop break only works on the first alarm.
      bus(1'b1, REG_KIND, 32'hcc);
      loopBreak <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk({30'h0, alarmOut[1:0]}, 32'h1);
      // Rate alarm over a one-sample period of four clocks.
      bus(1'b1, REG_KIND, 32'hd);
      vals(16'h2, 0, 0);
      ramp(16'h1);
      vals(16'hfffe, 0, 0);
      ramp(16'hffff);
      // Overlapping hysteresis bands keep the standby pair off.
      bus(1'b1, REG_KIND, 32'h5);
      bus(1'b1, REG_HYS, 32'ha);
      vals(0, 16'h5, 16'h5);
      processValue <= 16'hc8;
      repeat (3) @(posedge sys_clk);
      chk({31'h0, alarmOut[0]}, 32'h0);
      end_of_test;
   end
endmodule
`default_nettype wire
